// [src/str_consts.svh]
// constants for the sync terminal router: register offsets, fields, clock and resync rates
// assumes inclusion by the resync generator and the top module only
// Functional notes
// - each route drives one way only, source terminal to destination terminal
// - sync lines 0..6 are selectable route sources
// - sync lines 0..6 are selectable route destinations
// - line 7 input may only feed the master timebase select
// - import 10 or 20 MHz on line 7; export only local 20 MHz
// - local oscillator routes only to line 7 output, card-wide
// - backplane 10 MHz clock feeds only master timebase select
// - star trigger received only when card sits in slot 3 or higher
// - resync source is a 10 Hz square wave at 50 percent duty
// - resync clock routes only to sync lines 0..6
// - frame-received pulse is one bit time in last end-of-frame bit
// - transceiver fault rests high, asserts low on fault
// - one start trigger shared by all tasks of an interface
// - with no start source routed, trigger fires when communication begins
// - start trigger can be exported on any of lines 0..6
// - unsupported selections are rejected with an error, no route made
// - routed start trigger fires on first rising edge of its source; code also fires at once on a source already high when routed
// - unconnected master timebase select uses the local oscillator
`ifndef STR_CONSTS_SVH
`define STR_CONSTS_SVH
`define STR_ADDR_CMD      4'h0
`define STR_ADDR_STATUS   4'h4
`define STR_ADDR_CFG      4'h8
`define STR_ADDR_ROUTE0   4'hc
`define STR_CMD_SRC_LSB   0
`define STR_CMD_DST_LSB   8
`define STR_CMD_CONN_BIT  16
`define STR_CFG_FORM_LSB  0
`define STR_CFG_PXI_BIT   2
`define STR_CFG_SLOT_LSB  4
`define STR_MIN_STAR_SLOT 4'h3
`define STR_CLK_HZ        25000000
`define STR_RESYNC_HZ     10
`define STR_RESYNC_HALF   (`STR_CLK_HZ / (2 * `STR_RESYNC_HZ))
`endif

// [src/str_pkg.sv]
// types for the sync terminal router
// assumes str_consts.svh beside it
package str_pkg;
  typedef enum logic [3:0] {
    STR_SRC_LINE0, STR_SRC_LINE1, STR_SRC_LINE2, STR_SRC_LINE3,
    STR_SRC_LINE4, STR_SRC_LINE5, STR_SRC_LINE6,
    STR_SRC_TIMEBASE_LINE, STR_SRC_STAR, STR_SRC_BACKPLANE_10M,
    STR_SRC_LOCAL_OSC, STR_SRC_RESYNC, STR_SRC_FRAME_RX,
    STR_SRC_XCVR_FAULT, STR_SRC_START_TRIG, STR_SRC_NONE
  } str_src_e;
  // destinations 0..6 are lines, then line 7, master timebase, start trigger
  typedef enum logic [3:0] {
    STR_DST_LINE0, STR_DST_LINE1, STR_DST_LINE2, STR_DST_LINE3,
    STR_DST_LINE4, STR_DST_LINE5, STR_DST_LINE6,
    STR_DST_TIMEBASE_LINE, STR_DST_MASTER_TB, STR_DST_START_TRIG
  } str_dst_e;
  typedef struct packed {
    logic     connected;
    str_src_e source;
  } str_route_s;
  typedef struct packed {
    logic [1:0] form;   // 0 pci, 1 pxi, 2 small card
    logic [3:0] slot;
  } str_cfg_s;
endpackage : str_pkg

// [src/str_sync2.sv]
// two-flop synchroniser for a bus of pin inputs
// assumes inputs asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module str_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end
  assign q_o = sync_ff;
endmodule : str_sync2
`default_nettype wire

// [src/str_resync_gen.sv]
// 10 Hz half-duty resync clock generator
// assumes clock_i at 25 MHz; half period shortenable for simulation
`timescale 1ns/1ps
`default_nettype none
`include "str_consts.svh"
module str_resync_gen #(
  parameter int HALF = `STR_RESYNC_HALF
) (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  output logic      resync_o
);
  logic [23:0] cnt_ff;
  logic [23:0] nxt_cnt;
  logic        lvl_ff;
  logic        nxt_lvl;
  always_comb
  begin
    nxt_cnt = cnt_ff + 24'h1;
    nxt_lvl = lvl_ff;
    if (cnt_ff == 24'(HALF - 1))
    begin
      nxt_cnt = '0;
      nxt_lvl = ~lvl_ff; // equal halves give 50 percent duty
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end
  assign resync_o = lvl_ff;
endmodule : str_resync_gen
`default_nettype wire

// [src/str_router.sv]
// sync terminal router: routes card events to and from the sync bus
// assumes AXI4-Lite master on clock_i; pins asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "str_consts.svh"
module str_router
  import str_pkg::*;
#(
  parameter int RESYNC_HALF = `STR_RESYNC_HALF
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // axi4-lite write
  input  wire logic [3:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // axi4-lite read
  input  wire logic [3:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // sync bus lines 0..6, open drain style
  input  wire logic [6:0]  sync_line_i,
  output logic [6:0]       sync_line_o,
  output logic [6:0]       sync_line_oe_o,
  // timebase line 7
  input  wire logic        timebase_line_in_i,
  output logic             timebase_line_out_o,
  output logic             timebase_line_oe_o,
  // card sources
  input  wire logic        star_trigger_in_i,
  input  wire logic        backplane_10m_clock_in_i,
  input  wire logic        local_oscillator_src_i,
  input  wire logic        frame_received_pulse_i,
  input  wire logic        fault_n_i,
  input  wire logic        comm_begin_i,
  // card outputs
  output logic [1:0]       master_timebase_sel_o,
  output logic             start_trigger_o,
  output logic             cmd_error_o
);
  localparam int NDST = 10;
  logic [4:0] pin_s;
  logic       resync;
  str_route_s routes_ff [NDST];
  str_route_s nxt_routes [NDST];
  str_cfg_s   cfg_ff;
  str_cfg_s   nxt_cfg;
  logic       err_ff;
  logic       nxt_err;
  logic       start_ff;
  logic       nxt_start;
  logic       prev_src_ff;
  logic       nxt_prev_src;
  logic       aw_ff;
  logic       w_ff;
  logic [3:0] awa_ff;
  logic [31:0] wd_ff;
  logic       nxt_aw;
  logic       nxt_w;
  logic [3:0] nxt_awa;
  logic [31:0] nxt_wd;
  logic       bv_ff;
  logic       nxt_bv;
  logic       rv_ff;
  logic       nxt_rv;
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  logic [6:0] lines_s;
  logic       do_write;
  str_src_e   req_src;
  logic [3:0] req_dst;
  logic       req_conn;
  logic       legal;
  logic       start_lvl;
  logic [NDST*5-1:0] routes_flat;
  logic [NDST-1:0]   tb_misroute;

  default clocking cb_main @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  str_sync2 #(.W(12)) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     ({sync_line_i, timebase_line_in_i, star_trigger_in_i,
                backplane_10m_clock_in_i, frame_received_pulse_i,
                fault_n_i}),
    .q_o     ({lines_s, pin_s})
  );

  str_resync_gen #(.HALF(RESYNC_HALF)) u_resync (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .resync_o (resync)
  );

  // legality of one source/destination pair for the configured variant
  function automatic logic pair_ok(str_src_e s, logic [3:0] d,
                                   str_cfg_s c);
    logic line_dst;
    logic pxi;
    line_dst = (d < 4'd7);
    pxi = (c.form == 2'd1);
    pair_ok = 1'b0;
    case (s)
      STR_SRC_LINE0, STR_SRC_LINE1, STR_SRC_LINE2, STR_SRC_LINE3,
      STR_SRC_LINE4, STR_SRC_LINE5, STR_SRC_LINE6:
        pair_ok = (d == 4'(STR_DST_START_TRIG)) ||
                  (d == 4'(STR_DST_MASTER_TB));
      STR_SRC_TIMEBASE_LINE:
        pair_ok = (d == 4'(STR_DST_MASTER_TB));
      STR_SRC_BACKPLANE_10M:
        pair_ok = pxi && (d == 4'(STR_DST_MASTER_TB));
      STR_SRC_STAR:
        pair_ok = pxi && (c.slot >= `STR_MIN_STAR_SLOT) &&
                  (d == 4'(STR_DST_START_TRIG));
      STR_SRC_LOCAL_OSC:
        pair_ok = (c.form != 2'd2) &&
                  (d == 4'(STR_DST_TIMEBASE_LINE));
      STR_SRC_RESYNC:
        pair_ok = line_dst;
      STR_SRC_FRAME_RX, STR_SRC_XCVR_FAULT, STR_SRC_START_TRIG:
        pair_ok = line_dst;
      default:
        pair_ok = 1'b0;
    endcase
    if (d > 4'(STR_DST_START_TRIG))
      pair_ok = 1'b0;
  endfunction : pair_ok

  function automatic logic src_level(str_src_e s, logic [6:0] l,
                                     logic [4:0] p, logic rs,
                                     logic st);
    case (s)
      STR_SRC_LINE0, STR_SRC_LINE1, STR_SRC_LINE2, STR_SRC_LINE3,
      STR_SRC_LINE4, STR_SRC_LINE5, STR_SRC_LINE6:
        src_level = l[s[2:0]];
      STR_SRC_STAR:        src_level = p[3];
      STR_SRC_FRAME_RX:    src_level = p[1];
      STR_SRC_XCVR_FAULT:  src_level = p[0];
      STR_SRC_RESYNC:      src_level = rs;
      STR_SRC_START_TRIG:  src_level = st;
      default:             src_level = 1'b0;
    endcase
  endfunction : src_level

  assign req_src  = str_src_e'(wd_ff[`STR_CMD_SRC_LSB +: 4]);
  assign req_dst  = wd_ff[`STR_CMD_DST_LSB +: 4];
  assign req_conn = wd_ff[`STR_CMD_CONN_BIT];
  assign do_write = aw_ff && w_ff && !bv_ff;
  assign legal    = pair_ok(req_src, req_dst, cfg_ff);

  // register bus and route table
  always_comb
  begin
    nxt_aw  = aw_ff;
    nxt_w   = w_ff;
    nxt_awa = awa_ff;
    nxt_wd  = wd_ff;
    nxt_bv  = bv_ff && !bready_i;
    nxt_rv  = rv_ff && !rready_i;
    nxt_rd  = rd_ff;
    nxt_cfg = cfg_ff;
    nxt_err = err_ff;
    nxt_routes = routes_ff;
    if (awvalid_i && !aw_ff)
    begin
      nxt_aw  = 1'b1;
      nxt_awa = awaddr_i;
    end
    if (wvalid_i && !w_ff)
    begin
      nxt_w  = 1'b1;
      nxt_wd = wdata_i;
    end
    if (do_write)
    begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      if (awa_ff == `STR_ADDR_CMD && wstrb_i != 4'h0)
      begin
        if (req_conn && !legal)
          nxt_err = 1'b1; // rejected, table untouched
        else if (req_dst <= 4'(STR_DST_START_TRIG))
        begin
          nxt_err = 1'b0;
          nxt_routes[req_dst].connected = req_conn;
          nxt_routes[req_dst].source = req_src;
        end
        else
          nxt_err = 1'b1;
      end
      else if (awa_ff == `STR_ADDR_CFG)
      begin
        nxt_cfg.form = wd_ff[`STR_CFG_FORM_LSB +: 2];
        nxt_cfg.slot = wd_ff[`STR_CFG_SLOT_LSB +: 4];
      end
    end
    if (arvalid_i && !rv_ff)
    begin
      nxt_rv = 1'b1;
      case (araddr_i)
        `STR_ADDR_STATUS: nxt_rd = {29'h0, start_ff, ~pin_s[0], err_ff};
        `STR_ADDR_CFG:    nxt_rd = {24'h0, cfg_ff.slot, 2'h0, cfg_ff.form};
        `STR_ADDR_ROUTE0: nxt_rd = {27'h0, routes_ff[STR_DST_START_TRIG]};
        default:          nxt_rd = 32'h0;
      endcase
    end
  end

  // start trigger: first rising edge of routed source (or a source already high when routed), else comm begin
  assign start_lvl = src_level(routes_ff[STR_DST_START_TRIG].source,
                               lines_s, pin_s, resync, 1'b0);
  always_comb
  begin
    nxt_prev_src = start_lvl;
    nxt_start = start_ff;
    if (routes_ff[STR_DST_START_TRIG].connected)
    begin
      if (start_lvl && !prev_src_ff)
        nxt_start = 1'b1;
    end
    else if (comm_begin_i)
      nxt_start = 1'b1;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff <= 32'h0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      cfg_ff <= '0;
      err_ff <= 1'b0;
      start_ff <= 1'b0;
      prev_src_ff <= 1'b1;
      for (int i = 0; i < NDST; i++)
        routes_ff[i] <= '{connected: 1'b0, source: STR_SRC_NONE};
    end
    else
    begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      bv_ff <= nxt_bv;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      cfg_ff <= nxt_cfg;
      err_ff <= nxt_err;
      start_ff <= nxt_start;
      prev_src_ff <= nxt_prev_src;
      routes_ff <= nxt_routes;
    end
  end

  // line outputs: one direction only per route
  for (genvar g = 0; g < 7; g++)
  begin : g_line
    assign sync_line_oe_o[g] = routes_ff[g].connected;
    assign sync_line_o[g] = src_level(routes_ff[g].source, lines_s, pin_s,
                                      resync, start_ff);
  end

  // flat copy of the table and per-entry line 7 misuse, for the checks
  for (genvar g = 0; g < NDST; g++)
  begin : g_flat
    assign routes_flat[g*5 +: 5] = routes_ff[g];
    assign tb_misroute[g] = routes_ff[g].connected &&
                            (g != int'(STR_DST_MASTER_TB)) &&
                            (routes_ff[g].source == STR_SRC_TIMEBASE_LINE);
  end

  assign timebase_line_oe_o  = routes_ff[STR_DST_TIMEBASE_LINE].connected;
  assign timebase_line_out_o = timebase_line_oe_o &&
                               local_oscillator_src_i;
  // 0 local, 1 line 7, 2 backplane, 3 line 0..6
  always_comb
  begin
    master_timebase_sel_o = 2'd0;
    if (routes_ff[STR_DST_MASTER_TB].connected)
      case (routes_ff[STR_DST_MASTER_TB].source)
        STR_SRC_TIMEBASE_LINE: master_timebase_sel_o = 2'd1;
        STR_SRC_BACKPLANE_10M: master_timebase_sel_o = 2'd2;
        default:               master_timebase_sel_o = 2'd3;
      endcase
  end

  assign start_trigger_o = start_ff;
  assign cmd_error_o = err_ff;
  assign awready_o = !aw_ff;
  assign wready_o  = !w_ff;
  assign bvalid_o  = bv_ff;
  assign bresp_o   = 2'b00;
  assign arready_o = !rv_ff;
  assign rvalid_o  = rv_ff;
  assign rdata_o   = rd_ff;
  assign rresp_o   = 2'b00;

  AST_TB_IN_ONLY_MT: assert property (tb_misroute == '0)
    else $error("line 7 input routed away from master timebase");
  AST_REJECT_KEEPS: assert property (
    (do_write && awa_ff == `STR_ADDR_CMD && wstrb_i != 4'h0 &&
     req_conn && !legal) |=> ($stable(routes_flat) && err_ff))
    else $error("rejected request changed routes");
  AST_OSC_ONLY_L7: assert property (
    routes_ff[STR_DST_TIMEBASE_LINE].connected
    |-> routes_ff[STR_DST_TIMEBASE_LINE].source == STR_SRC_LOCAL_OSC)
    else $error("line 7 driven by non oscillator");
  AST_START_STICKY: assert property (start_ff |=> start_ff)
    else $error("start trigger dropped");
  AST_COMM_START: assert property (
    (!routes_ff[STR_DST_START_TRIG].connected && comm_begin_i)
    |=> start_trigger_o)
    else $error("no start on comm begin");
  sequence s_start_rise;
    routes_ff[STR_DST_START_TRIG].connected && start_lvl && !prev_src_ff;
  endsequence
  AST_START_RISE: assert property (s_start_rise |=> start_ff)
    else $error("routed source rose without start");
endmodule : str_router
`default_nettype wire

// [dv/str_partner.sv]
// other cards sharing the sync bus, as seen from this card
// assumes pull-ups on lines 0..6; link clock stands still unless enabled
`timescale 1ns/1ps
`default_nettype none
module str_partner (
  // design side of lines 0..6
  input  wire logic [6:0] dut_o_i,
  input  wire logic [6:0] dut_oe_i,
  // what the other cards drive
  input  wire logic [6:0] lvl_i,
  input  wire logic [6:0] drv_i,
  input  wire logic       tb_en_i,
  // resolved wire levels
  output logic      [6:0] line_o,
  output logic            tb_line_o
);
  // a released line floats to the pull-up, never to its last value
  assign line_o = (~dut_oe_i | dut_o_i) & (~drv_i | lvl_i);
  logic clk_q = 1'b0;
  // supplying card drives its 320 ns timebase only while it exports
  always #160 clk_q = tb_en_i ? ~clk_q : 1'b0;
  assign tb_line_o = clk_q;
endmodule : str_partner
`default_nettype wire

// [dv/tb.sv]
// register-level bench for the sync terminal router
// assumes str_partner beside it; resync half period shortened to 4
`timescale 1ns/1ps
`default_nettype none
module tb
  import str_pkg::*;
  ;
  localparam int HALF = 4;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [3:0]  awaddr  = 4'h0;
  logic [3:0]  araddr  = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        star    = 1'b0;
  logic        bp      = 1'b0;
  logic        osc     = 1'b0;
  logic        frx     = 1'b0;
  logic        fltn    = 1'b1;
  logic        comm    = 1'b0;
  logic        ten     = 1'b0;
  logic [6:0]  lvl     = 7'h0;
  logic [6:0]  drv     = 7'h0;
  logic        awready, wready, bvalid, arready, rvalid, tbo, tboe;
  logic        st, err, tbl;
  logic [1:0]  bresp, rresp, sel;
  logic [31:0] rdata;
  logic [6:0]  lo, loe, lines;
  int          error_cnt = 0;
  int          checks = 0;
  int          tick = 0;
  int          n, m;

  str_router #(.RESYNC_HALF(HALF)) u_str_router (
    .clock_i(clock_i), .rst_b_i(rst_b_i),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
    .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
    .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
    .rvalid_o(rvalid), .rready_i(rready),
    .sync_line_i(lines), .sync_line_o(lo), .sync_line_oe_o(loe),
    .timebase_line_in_i(tbl), .timebase_line_out_o(tbo),
    .timebase_line_oe_o(tboe), .star_trigger_in_i(star),
    .backplane_10m_clock_in_i(bp), .local_oscillator_src_i(osc),
    .frame_received_pulse_i(frx), .fault_n_i(fltn),
    .comm_begin_i(comm), .master_timebase_sel_o(sel),
    .start_trigger_o(st), .cmd_error_o(err));
  str_partner u_str_partner (
    .dut_o_i(lo), .dut_oe_i(loe), .lvl_i(lvl), .drv_i(drv),
    .tb_en_i(ten), .line_o(lines), .tb_line_o(tbl));

  always #20 clock_i = ~clock_i;

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge clock_i)
  begin
    tick <= tick + 1;
    if (tick == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask : cyc

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // payloads stay up until their own channel takes them
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
  endtask : rc

  task automatic cmd(input str_src_e s, input str_dst_e d,
                     input logic c, input logic e);
    wr(4'h0, {15'h0, c, 4'h0, d, 4'h0, s});
    cyc(3);
    chk(32'(err), 32'(e));
  endtask : cmd

  // high run, then low run bounded so a lasting low after the high run cannot hang
  task automatic run(input int b);
    n = 0;
    m = 0;
    // skip a high run already under way, so only whole runs are counted
    while (lo[b] === 1'b1)
      @(posedge clock_i);
    while (lo[b] !== 1'b1)
      @(posedge clock_i);
    while (lo[b] === 1'b1)
    begin
      n++;
      @(posedge clock_i);
    end
    while (lo[b] === 1'b0 && m < 64)
    begin
      m++;
      @(posedge clock_i);
    end
  endtask : run

  task automatic pulse_comm();
    comm <= 1'b1;
    cyc(1);
    comm <= 1'b0;
    cyc(4);
  endtask : pulse_comm

  initial
  begin
    cyc(16);
    rst_b_i <= 1'b1;
    cyc(2);
    rc(4'h4, 32'h0);
    chk(32'({loe, tboe, sel}), 32'h0);
    wr(4'h8, 32'h21);
    rc(4'h8, 32'h21);
    // other card holds line 5 low; the route must not read it back
    drv <= 7'h20;
    cmd(STR_SRC_XCVR_FAULT, STR_DST_LINE5, 1'b1, 1'b0);
    chk(32'(loe), 32'h20);
    chk(32'(lo[5]), 32'h1);
    fltn <= 1'b0;
    cyc(4);
    chk(32'(lo[5]), 32'h0);
    fltn <= 1'b1;
    cmd(STR_SRC_LINE2, STR_DST_LINE5, 1'b1, 1'b1);
    cmd(STR_SRC_TIMEBASE_LINE, STR_DST_LINE0, 1'b1, 1'b1);
    cmd(STR_SRC_LOCAL_OSC, STR_DST_LINE1, 1'b1, 1'b1);
    cmd(STR_SRC_BACKPLANE_10M, STR_DST_LINE1, 1'b1, 1'b1);
    cmd(STR_SRC_RESYNC, STR_DST_MASTER_TB, 1'b1, 1'b1);
    cmd(STR_SRC_STAR, STR_DST_START_TRIG, 1'b1, 1'b1);
    cmd(STR_SRC_LINE3, STR_DST_TIMEBASE_LINE, 1'b1, 1'b1);
    rc(4'h4, 32'h1);
    chk(32'({loe, tboe, sel}), 32'h100);
    osc <= 1'b1;
    cmd(STR_SRC_LOCAL_OSC, STR_DST_TIMEBASE_LINE, 1'b1, 1'b0);
    chk(32'({tboe, tbo}), 32'h3);
    osc <= 1'b0;
    cyc(4);
    chk(32'(tbo), 32'h0);
    ten <= 1'b1;
    cmd(STR_SRC_TIMEBASE_LINE, STR_DST_MASTER_TB, 1'b1, 1'b0);
    chk(32'(sel), 32'h1);
    cmd(STR_SRC_BACKPLANE_10M, STR_DST_MASTER_TB, 1'b1, 1'b0);
    chk(32'(sel), 32'h2);
    cmd(STR_SRC_LINE0, STR_DST_MASTER_TB, 1'b1, 1'b0);
    chk(32'(sel), 32'h3);
    cmd(STR_SRC_LINE0, STR_DST_MASTER_TB, 1'b0, 1'b0);
    chk(32'(sel), 32'h0);
    ten <= 1'b0;
    wr(4'h8, 32'h30);
    cmd(STR_SRC_BACKPLANE_10M, STR_DST_MASTER_TB, 1'b1, 1'b1);
    cmd(STR_SRC_STAR, STR_DST_START_TRIG, 1'b1, 1'b1);
    wr(4'h8, 32'h31);
    star <= 1'b1;
    cmd(STR_SRC_STAR, STR_DST_START_TRIG, 1'b1, 1'b0);
    chk(32'(st), 32'h1);
    // the star test fires the sticky start; reset rearms it
    star <= 1'b0;
    rst_b_i <= 1'b0;
    cyc(16);
    rst_b_i <= 1'b1;
    cyc(2);
    wr(4'h8, 32'h32);
    cmd(STR_SRC_LOCAL_OSC, STR_DST_TIMEBASE_LINE, 1'b1, 1'b1);
    cmd(STR_SRC_RESYNC, STR_DST_LINE4, 1'b1, 1'b0);
    run(4);
    chk(32'(n), 32'(HALF));
    chk(32'(m), 32'(HALF));
    cmd(STR_SRC_FRAME_RX, STR_DST_LINE6, 1'b1, 1'b0);
    fork
      begin
        cyc(2);
        frx <= 1'b1;
        cyc(3);
        frx <= 1'b0;
      end
      run(6);
    join
    chk(32'(n), 32'h3);
    cmd(STR_SRC_XCVR_FAULT, STR_DST_LINE1, 1'b1, 1'b0);
    chk(32'(lo[1]), 32'h1);
    fltn <= 1'b0;
    cyc(4);
    chk(32'(lo[1]), 32'h0);
    rc(4'h4, 32'h2);
    fltn <= 1'b1;
    cmd(STR_SRC_START_TRIG, STR_DST_LINE0, 1'b1, 1'b0);
    chk(32'({st, lo[0]}), 32'h0);
    pulse_comm();
    chk(32'(st), 32'h1);
    chk(32'(lo[0]), 32'h1);
    rc(4'h4, 32'h4);
    // start trigger is sticky, so only a reset rearms it
    rst_b_i <= 1'b0;
    lvl <= 7'h00;
    drv <= 7'h20;
    cyc(16);
    rst_b_i <= 1'b1;
    cyc(2);
    wr(4'h8, 32'h31);
    cmd(STR_SRC_LINE5, STR_DST_START_TRIG, 1'b1, 1'b0);
    rc(4'hc, 32'h15);
    pulse_comm();
    chk(32'(st), 32'h0);
    lvl <= 7'h20;
    cyc(4);
    chk(32'(st), 32'h1);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
